// ### core/stc_pkg.sv
// Package and pin synchroniser for the sixteen bit timer control block
package stc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] STC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] STC_ADDR_COUNT = 4'h1;
  localparam logic [3:0] STC_ADDR_PERIOD = 4'h2;
  // Control register bit positions
  localparam int STC_BIT_RUN = 15;
  localparam int STC_BIT_IDLE_HALT = 13;
  localparam int STC_BIT_WBLOCK = 12;
  localparam int STC_BIT_CWIP = 11;
  localparam int STC_BIT_PWIP = 10;
  localparam int STC_BIT_EXTENDED_CLOCK_SELECT = 8;
  localparam int STC_BIT_GATE = 7;
  localparam int STC_BIT_PRESC = 4;
  localparam int STC_BIT_SYNC = 2;
  localparam int STC_BIT_TCS = 1;
  // Reset values
  localparam logic [15:0] STC_RST_CTRL = 16'h0000;
  localparam logic [15:0] STC_RST_COUNT = 16'h0000;
  localparam logic [15:0] STC_RST_PERIOD = 16'hffff;
  // Extended clock selector codes
  localparam logic [1:0] STC_EXTENDED_CLOCK_SELECT_PIN = 2'h0;
  localparam logic [1:0] STC_EXTENDED_CLOCK_SELECT_RSVD = 2'h1;
  localparam logic [1:0] STC_EXTENDED_CLOCK_SELECT_DIV2 = 2'h2;
  localparam logic [1:0] STC_EXTENDED_CLOCK_SELECT_OSC = 2'h3;
  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] STC_PRE_1 = 8'h00;
  localparam logic [7:0] STC_PRE_8 = 8'h07;
  localparam logic [7:0] STC_PRE_64 = 8'h3f;
  localparam logic [7:0] STC_PRE_256 = 8'hff;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } stc_bus_req_t;

  typedef struct packed {
    logic run;
    logic idle_halt;
    logic async_write_block;
    logic [1:0] extended_clock_select;
    logic gated_accumulate;
    logic [1:0] prescale_select;
    logic external_sync;
    logic clock_source_select;
  } stc_ctrl_t;

  // Terminal count of the prescaler for a select code
  function automatic logic [7:0] stc_pre_term(input logic [1:0] sel);
    unique case (sel)
      2'h0: stc_pre_term = STC_PRE_1;
      2'h1: stc_pre_term = STC_PRE_8;
      2'h2: stc_pre_term = STC_PRE_64;
      2'h3: stc_pre_term = STC_PRE_256;
    endcase
  endfunction : stc_pre_term
endpackage : stc_pkg

`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Three-stage synchroniser; level moves only once stages two and three agree
module stc_pin_sync
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;

  // Shift chain; s1 feeds only s2 so metastability never reaches logic
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered level and its rising edge pulse
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      if (s2 == s3)
        level <= s3;
      rise <= (s2 == s3) && s3 && !level;
    end
  end
endmodule : stc_pin_sync

// ### core/stc_timer.sv
// Sixteen bit timer with control, count and period registers
// Operation
// - Idle halt bit set stops the timer while the device idles.
// - Extended selector: 11 fast oscillator, 10 half system clock, 00 external pin.
// - Gated accumulation works only when clock source select is zero.
// - External synchronous counter running ignores software count writes.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module stc_timer
  import stc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire stc_pkg::stc_bus_req_t bus,
  output logic [15:0] rd_data,
  input wire logic ext_count_pin,
  input wire logic fast_internal_osc,
  input wire logic idle_mode,
  output logic [15:0] count_value,
  output logic period_match
);
  import stc_pkg::*;

  stc_ctrl_t ctrl;
  logic [15:0] period_value;
  logic count_write_pending;
  logic period_write_pending;
  logic [15:0] count_post;
  logic [15:0] period_post;
  logic [7:0] pre_cnt;
  logic div2;
  logic ext_level;
  logic ext_rise;
  logic osc_rise;
  logic src_tick;
  logic running;
  logic async_mode;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic count_ignored;
  logic count_direct;
  logic count_posted;
  logic inc_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  stc_pin_sync u_ext_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(ext_count_pin),
    .level(ext_level),
    .rise(ext_rise)
  );

  stc_pin_sync u_osc_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(fast_internal_osc),
    .level(),
    .rise(osc_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode; async mode is the external clock taken without resync
  assign wr_ctrl = bus.wr && (bus.addr == STC_ADDR_CTRL);
  assign wr_count = bus.wr && (bus.addr == STC_ADDR_COUNT);
  assign wr_period = bus.wr && (bus.addr == STC_ADDR_PERIOD);
  assign async_mode = ctrl.clock_source_select && !ctrl.external_sync;
  assign count_ignored = wr_count && ctrl.clock_source_select && ctrl.external_sync && ctrl.run;
  assign count_posted = wr_count && async_mode && !(ctrl.async_write_block && count_write_pending);
  assign count_direct = wr_count && !async_mode && !count_ignored;
  assign running = ctrl.run && !(ctrl.idle_halt && idle_mode);

  // Source tick selection; internal clock with gate counts while pin is high
  always_comb
  begin
    src_tick = 1'b0;
    if (!ctrl.clock_source_select)
      src_tick = ctrl.gated_accumulate ? ext_level : 1'b1;
    else
    begin
      unique case (ctrl.extended_clock_select)
        STC_EXTENDED_CLOCK_SELECT_PIN: src_tick = ext_rise;
        STC_EXTENDED_CLOCK_SELECT_RSVD: src_tick = 1'b0;
        STC_EXTENDED_CLOCK_SELECT_DIV2: src_tick = div2;
        STC_EXTENDED_CLOCK_SELECT_OSC: src_tick = osc_rise;
      endcase
    end
  end

  assign inc_tick = running && src_tick && (pre_cnt == stc_pre_term(ctrl.prescale_select));

  ////////////////////////////////////////////////////////////////////////////////
  // Control register; pending flags are read-only and not stored here
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= '0;
    else if (wr_ctrl)
    begin
      ctrl.run <= bus.wdata[STC_BIT_RUN];
      ctrl.idle_halt <= bus.wdata[STC_BIT_IDLE_HALT];
      ctrl.async_write_block <= bus.wdata[STC_BIT_WBLOCK];
      ctrl.extended_clock_select <= bus.wdata[STC_BIT_EXTENDED_CLOCK_SELECT +: 2];
      ctrl.gated_accumulate <= bus.wdata[STC_BIT_GATE];
      ctrl.prescale_select <= bus.wdata[STC_BIT_PRESC +: 2];
      ctrl.external_sync <= bus.wdata[STC_BIT_SYNC];
      ctrl.clock_source_select <= bus.wdata[STC_BIT_TCS];
    end
  end

  // Half system clock tick for selector code 10
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div2 <= 1'b0;
    else
      div2 <= !div2;
  end

  // Prescaler; cleared when stopped so a restart begins a full division
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt <= 8'h00;
    else if (!running)
      pre_cnt <= 8'h00;
    else if (src_tick)
      pre_cnt <= (pre_cnt == stc_pre_term(ctrl.prescale_select)) ? 8'h00 : pre_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Async count posting; a write in the clearing tick wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_write_pending <= 1'b0;
      count_post <= STC_RST_COUNT;
    end
    else if (count_posted)
    begin
      count_write_pending <= 1'b1;
      count_post <= bus.wdata;
    end
    else if (src_tick)
      count_write_pending <= 1'b0;
  end

  // Async period posting; period writes are never blocked
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_write_pending <= 1'b0;
      period_post <= STC_RST_PERIOD;
    end
    else if (wr_period && async_mode)
    begin
      period_write_pending <= 1'b1;
      period_post <= bus.wdata;
    end
    else if (src_tick)
      period_write_pending <= 1'b0;
  end

  // Period register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      period_value <= STC_RST_PERIOD;
    else if (wr_period && !async_mode)
      period_value <= bus.wdata;
    else if (period_write_pending && src_tick)
      period_value <= period_post;
  end

  // Counter: direct write, then posted apply, then count with period wrap
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count_value <= STC_RST_COUNT;
    else if (count_direct)
      count_value <= bus.wdata;
    else if (count_write_pending && src_tick)
      count_value <= count_post;
    else if (inc_tick)
      count_value <= (count_value == period_value) ? 16'h0000 : count_value + 16'h0001;
  end

  // Period match pulse
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      period_match <= 1'b0;
    else
      period_match <= inc_tick && (count_value == period_value);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe; unmapped read zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else if (!bus.rd)
      rd_data <= 16'h0000;
    else
    begin
      unique case (bus.addr)
        STC_ADDR_CTRL:
        begin
          rd_data <= 16'h0000;
          rd_data[STC_BIT_RUN] <= ctrl.run;
          rd_data[STC_BIT_IDLE_HALT] <= ctrl.idle_halt;
          rd_data[STC_BIT_WBLOCK] <= ctrl.async_write_block;
          rd_data[STC_BIT_CWIP] <= count_write_pending;
          rd_data[STC_BIT_PWIP] <= period_write_pending;
          rd_data[STC_BIT_EXTENDED_CLOCK_SELECT +: 2] <= ctrl.extended_clock_select;
          rd_data[STC_BIT_GATE] <= ctrl.gated_accumulate;
          rd_data[STC_BIT_PRESC +: 2] <= ctrl.prescale_select;
          rd_data[STC_BIT_SYNC] <= ctrl.external_sync;
          rd_data[STC_BIT_TCS] <= ctrl.clock_source_select;
        end
        STC_ADDR_COUNT: rd_data <= count_value;
        STC_ADDR_PERIOD: rd_data <= period_value;
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence stc_post_s;
    count_posted;
  endsequence

  sequence stc_hold_s;
    count_write_pending[*1];
  endsequence

  run_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ctrl.run && !bus.wr && !count_write_pending) |=> $stable(count_value))
    else $error("count moved while stopped");

  idle_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.run && ctrl.idle_halt && idle_mode && !bus.wr && !count_write_pending) |=> $stable(count_value))
    else $error("count moved in idle with halt set");

  idle_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.run && !ctrl.idle_halt && !ctrl.clock_source_select && !ctrl.gated_accumulate
     && ctrl.prescale_select == 2'h0 && !bus.wr && count_value != period_value)
    |=> count_value == $past(count_value) + 16'h0001)
    else $error("count did not advance in idle without halt");

  rsvd_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.clock_source_select && ctrl.extended_clock_select == STC_EXTENDED_CLOCK_SELECT_RSVD) |-> !src_tick)
    else $error("reserved source produced a tick");

  div2_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.clock_source_select && ctrl.extended_clock_select == STC_EXTENDED_CLOCK_SELECT_DIV2 && src_tick)
    |=> !(ctrl.clock_source_select && ctrl.extended_clock_select == STC_EXTENDED_CLOCK_SELECT_DIV2 && src_tick))
    else $error("half clock source ticked twice in a row");

  gate_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ctrl.clock_source_select && !ctrl.gated_accumulate) |-> src_tick)
    else $error("ungated internal clock missed a tick");

  gate_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ctrl.clock_source_select && ctrl.gated_accumulate && !ext_level) |-> !src_tick)
    else $error("gated accumulation counted with gate low");

  sync_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count_ignored |=> (count_value == $past(count_value)) || (count_value == $past(count_value) + 16'h0001)
    || (count_value == 16'h0000))
    else $error("count write taken in external sync mode");

  post_pend_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stc_post_s |=> stc_hold_s)
    else $error("posted count write did not raise pending");

  pend_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count_write_pending && !src_tick) |=> count_write_pending)
    else $error("pending flag dropped before sync tick");

  write_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count_write_pending && ctrl.async_write_block && wr_count && !src_tick) |=> $stable(count_post))
    else $error("blocked count write replaced posted value");
endmodule : stc_timer

// ### verification/stc_pin_model.sv
// Far side model: drives the external count pin and the fast oscillator line
`timescale 1ns/1ps
module stc_pin_model
(
  input wire logic clk_sys,
  output logic ext_count_pin,
  output logic fast_internal_osc
);
  logic [1:0] lvl;
  // Both lines rest low between bursts; nothing runs free
  initial lvl = 2'h0;
  assign ext_count_pin = lvl[0];
  assign fast_internal_osc = lvl[1];
  //////////////////////////////////////////////////
  // Pulses of 4 clocks high and 4 low, above the synchroniser minimum of 2
  task automatic burst(input int n, input int line);
    repeat (n)
    begin
      lvl[line] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lvl[line] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : burst
  // Holds the pin at a level, used as the gate input
  task automatic hold(input logic v);
    lvl[0] <= v;
    @(posedge clk_sys);
  endtask : hold
endmodule : stc_pin_model

// ### verification/tb.sv
// Self-checking testbench for the sixteen bit timer control block
`timescale 1ns/1ps
module tb;
  import stc_pkg::*;
  logic clk_sys, rst_n, idle_mode, period_match, ext_count_pin, fast_internal_osc;
  stc_bus_req_t bus;
  logic [15:0] rd_data, count_value, a, v;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // Selector code, pulse count, line and expected count for each source
  logic [1:0] sel_c [3] = '{2'h0, 2'h3, 2'h1};
  int n_c [3] = '{5, 3, 4};
  int line_c [3] = '{0, 1, 0};
  logic [15:0] exp_c [3] = '{16'h0005, 16'h0003, 16'h0000};
  stc_timer uut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .ext_count_pin(ext_count_pin),
    .fast_internal_osc(fast_internal_osc), .idle_mode(idle_mode), .count_value(count_value),
    .period_match(period_match));
  stc_pin_model pm (.clk_sys(clk_sys), .ext_count_pin(ext_count_pin), .fast_internal_osc(fast_internal_osc));
  //////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Cuts a hang short; the full run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Bus cycles leave one idle cycle so no strobe is assigned twice in a step
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge clk_sys);
  endtask : rd
  task automatic rchk(input logic [3:0] ad, input logic [15:0] exp, input string what);
    logic [15:0] d;
    rd(ad, d);
    check(what, d, exp);
  endtask : rchk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    bus = '0;
    rst_n = 1'b0;
    idle_mode = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk(STC_ADDR_CTRL, STC_RST_CTRL, "ctrl reset");
    rchk(STC_ADDR_COUNT, STC_RST_COUNT, "count reset");
    rchk(STC_ADDR_PERIOD, STC_RST_PERIOD, "period reset");
    rchk(4'h3, 16'h0000, "unmapped");
    // All ones: external sync counter running, pending flags stay read-only
    wr(STC_ADDR_CTRL, 16'hffff);
    rchk(STC_ADDR_CTRL, 16'hb3b6, "ctrl mask");
    wr(STC_ADDR_COUNT, 16'h1234);
    rchk(STC_ADDR_COUNT, 16'h0000, "count write ignored");
    wr(STC_ADDR_CTRL, 16'h0000);
    wr(STC_ADDR_COUNT, 16'h1234);
    rchk(STC_ADDR_COUNT, 16'h1234, "count write");
    // Run about twelve clocks, then stop and hold
    wr(STC_ADDR_CTRL, 16'h8000);
    repeat (10) @(posedge clk_sys);
    wr(STC_ADDR_CTRL, 16'h0000);
    rd(STC_ADDR_COUNT, a);
    check("run span", {15'h0000, (a > 16'h123d) && (a < 16'h1243)}, 16'h0001);
    repeat (5) @(posedge clk_sys);
    rchk(STC_ADDR_COUNT, a, "count held");
    check("count port", count_value, a);
    // Idle halt
    wr(STC_ADDR_COUNT, 16'h0000);
    idle_mode <= 1'b1;
    wr(STC_ADDR_CTRL, 16'ha000);
    repeat (6) @(posedge clk_sys);
    rchk(STC_ADDR_COUNT, 16'h0000, "idle halted");
    idle_mode <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(STC_ADDR_COUNT, a);
    check("idle resumes", {15'h0000, a != 16'h0000}, 16'h0001);
    idle_mode <= 1'b1;
    wr(STC_ADDR_CTRL, 16'h8000);
    rd(STC_ADDR_COUNT, a);
    rd(STC_ADDR_COUNT, v);
    check("idle runs", {15'h0000, v != a}, 16'h0001);
    idle_mode <= 1'b0;
    // Pin, oscillator and reserved selector codes
    for (int i = 0; i < 3; i++)
    begin
      wr(STC_ADDR_CTRL, 16'h0000);
      wr(STC_ADDR_COUNT, 16'h0000);
      wr(STC_ADDR_CTRL, 16'h8006 | {6'h00, sel_c[i], 8'h00});
      pm.burst(n_c[i], line_c[i]);
      repeat (8) @(posedge clk_sys);
      rchk(STC_ADDR_COUNT, exp_c[i], "source count");
    end
    // Half clock source: about eleven ticks in twenty two clocks
    wr(STC_ADDR_CTRL, 16'h0000);
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h8206);
    repeat (20) @(posedge clk_sys);
    wr(STC_ADDR_CTRL, 16'h0000);
    rd(STC_ADDR_COUNT, a);
    check("half clock", {15'h0000, (a > 16'h0008) && (a < 16'h000e)}, 16'h0001);
    // Gated accumulation counts only while the pin is high
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h8080);
    repeat (8) @(posedge clk_sys);
    rchk(STC_ADDR_COUNT, 16'h0000, "gate closed");
    pm.hold(1'b1);
    repeat (15) @(posedge clk_sys);
    pm.hold(1'b0);
    repeat (8) @(posedge clk_sys);
    rd(STC_ADDR_COUNT, a);
    check("gate open", {15'h0000, (a > 16'h000d) && (a < 16'h0013)}, 16'h0001);
    wr(STC_ADDR_CTRL, 16'h0000);
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h8286);
    repeat (20) @(posedge clk_sys);
    rd(STC_ADDR_COUNT, a);
    check("gate ignored", {15'h0000, a != 16'h0000}, 16'h0001);
    // Posted writes in async mode, stopped, with the write block on
    wr(STC_ADDR_CTRL, 16'h0000);
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h1002);
    wr(STC_ADDR_COUNT, 16'h0042);
    rchk(STC_ADDR_CTRL, 16'h1802, "count pending");
    wr(STC_ADDR_PERIOD, 16'h0030);
    rchk(STC_ADDR_CTRL, 16'h1c02, "period pending");
    wr(STC_ADDR_COUNT, 16'h0077);
    pm.burst(1, 0);
    repeat (8) @(posedge clk_sys);
    rchk(STC_ADDR_CTRL, 16'h1002, "pending cleared");
    rchk(STC_ADDR_COUNT, 16'h0042, "blocked write");
    rchk(STC_ADDR_PERIOD, 16'h0030, "posted period");
    // Block off: the later of two back-to-back writes lands
    wr(STC_ADDR_CTRL, 16'h0002);
    wr(STC_ADDR_COUNT, 16'h0011);
    wr(STC_ADDR_COUNT, 16'h0022);
    pm.burst(1, 0);
    repeat (8) @(posedge clk_sys);
    rchk(STC_ADDR_COUNT, 16'h0022, "last write wins");
    // Period 3 wraps every 4 clocks: 3 pulses in any 12 clocks
    wr(STC_ADDR_CTRL, 16'h0000);
    wr(STC_ADDR_PERIOD, 16'h0003);
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h8000);
    a = 16'h0000;
    repeat (12)
    begin
      @(posedge clk_sys);
      #1;
      if (period_match === 1'b1)
        a = a + 16'h0001;
    end
    check("wrap pulses", a, 16'h0003);
    wr(STC_ADDR_CTRL, 16'h0000);
    // Prescale 1:8 on the system clock: three steps in twenty eight running clocks
    wr(STC_ADDR_COUNT, 16'h0000);
    wr(STC_ADDR_CTRL, 16'h8010);
    repeat (26) @(posedge clk_sys);
    wr(STC_ADDR_CTRL, 16'h0000);
    rchk(STC_ADDR_COUNT, 16'h0003, "prescale 8");
    give_verdict();
  end
endmodule : tb
